// ---- design/mss_top.sv ----
// Memory size configuration registers and programming-mode entry logic.
// Assumes a byte-wide CPU memory port on core_clk and a strap pin from
// outside the clock domain.
`timescale 1ns/10ps
module mss_top
	import mss_pkg::*;
(
	core_clk,
	rst_b,
	cpu_addr,
	cpu_wr_en,
	cpu_rd_en,
	cpu_byte_acc,
	cpu_wdata,
	cpu_rdata,
	cpu_rd_hit,
	program_mode_select_pin,
	prog_chan_sel,
	clk_src_sel,
	hs_ram_bytes,
	code_store_kb,
	expansion_bytes,
	size_code_bad,
	prog_mode,
	prog_clk_ok,
	clocked_serial_channel_en,
	async_serial_channel_en
);
	input wire logic core_clk;
	input wire logic rst_b;
	input wire logic [15:0] cpu_addr;
	input wire logic cpu_wr_en;
	input wire logic cpu_rd_en;
	input wire logic cpu_byte_acc;
	input wire logic [7:0] cpu_wdata;
	output logic [7:0] cpu_rdata;
	output logic cpu_rd_hit;
	input wire logic program_mode_select_pin;
	input wire mss_pkg::mss_chan_t prog_chan_sel;
	input wire mss_pkg::mss_clk_src_t clk_src_sel;
	output logic [10:0] hs_ram_bytes;
	output logic [5:0] code_store_kb;
	output logic [10:0] expansion_bytes;
	output logic [2:0] size_code_bad;
	output logic prog_mode;
	output logic prog_clk_ok;
	output logic clocked_serial_channel_en;
	output logic async_serial_channel_en;

	mss_reg_if mem_if ();
	mss_reg_if exp_if ();

	// Address decode
	wire sel_mem = (cpu_addr == MEM_SIZE_ADDR);
	wire sel_exp = (cpu_addr == EXP_SIZE_ADDR);
	wire hit = sel_mem | sel_exp;

	// Bit-manipulation writes are dropped: a read-modify-write of a
	// single bit could leave a prohibited size code for one cycle
	assign mem_if.wr_en = cpu_wr_en & cpu_byte_acc & sel_mem;
	assign mem_if.wdata = cpu_wdata;
	assign exp_if.wr_en = cpu_wr_en & cpu_byte_acc & sel_exp;
	assign exp_if.wdata = cpu_wdata;

	mss_byte_reg #(
		.RST_VAL(MEM_SIZE_RST),
		.WR_MASK(MEM_SIZE_MASK)
	) u_mem_size_select (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.bus(mem_if)
	);

	mss_byte_reg #(
		.RST_VAL(EXP_SIZE_RST),
		.WR_MASK(EXP_SIZE_MASK)
	) u_expansion_ram_size_select (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.bus(exp_if)
	);

	wire [7:0] memory_size_select = mem_if.q;
	wire [7:0] expansion_ram_size_select = exp_if.q;

	// Read mux; unmapped addresses return zero with no hit
	wire [7:0] rd_mux = sel_mem ? memory_size_select :
		(sel_exp ? expansion_ram_size_select : 8'h00);
	assign cpu_rdata = rd_mux;
	assign cpu_rd_hit = cpu_rd_en & hit;

	// Field extraction
	wire [2:0] ram_fld = memory_size_select[RAM_FLD_MSB:RAM_FLD_LSB];
	wire [3:0] rom_fld = memory_size_select[ROM_FLD_MSB:ROM_FLD_LSB];
	wire [4:0] exp_fld = expansion_ram_size_select[EXP_FLD_MSB:EXP_FLD_LSB];

	// Capacity decode; a prohibited code keeps the smallest capacity so
	// a bad write never exposes memory that may not exist
	logic [10:0] nxt_ram_bytes;
	logic [5:0] nxt_rom_kb;
	logic [10:0] nxt_exp_bytes;
	logic [2:0] nxt_bad;

	always_comb begin
		nxt_bad = 3'h0;
		case (ram_fld)
			RAM_CODE_768: nxt_ram_bytes = RAM_BYTES_768;
			RAM_CODE_1024: nxt_ram_bytes = RAM_BYTES_1024;
			default: begin
				nxt_ram_bytes = RAM_BYTES_768;
				nxt_bad[0] = 1'b1;
			end
		endcase
		case (rom_fld)
			ROM_CODE_16K: nxt_rom_kb = ROM_KB_16;
			ROM_CODE_24K: nxt_rom_kb = ROM_KB_24;
			ROM_CODE_32K: nxt_rom_kb = ROM_KB_32;
			ROM_CODE_48K: nxt_rom_kb = ROM_KB_48;
			ROM_CODE_60K: nxt_rom_kb = ROM_KB_60;
			default: begin
				nxt_rom_kb = ROM_KB_16;
				nxt_bad[1] = 1'b1;
			end
		endcase
		case (exp_fld)
			EXP_CODE_NONE: nxt_exp_bytes = EXP_BYTES_NONE;
			EXP_CODE_1024: nxt_exp_bytes = EXP_BYTES_1024;
			default: begin
				nxt_exp_bytes = EXP_BYTES_NONE;
				nxt_bad[2] = 1'b1;
			end
		endcase
	end

	logic [10:0] ram_bytes_ff;
	logic [5:0] rom_kb_ff;
	logic [10:0] exp_bytes_ff;
	logic [2:0] bad_ff;

	// Reset values match the decode of the register reset values
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ram_bytes_ff <= RAM_BYTES_1024;
			rom_kb_ff <= ROM_KB_60;
			exp_bytes_ff <= EXP_BYTES_NONE;
			bad_ff <= 3'h0;
		end else begin
			ram_bytes_ff <= nxt_ram_bytes;
			rom_kb_ff <= nxt_rom_kb;
			exp_bytes_ff <= nxt_exp_bytes;
			bad_ff <= nxt_bad;
		end
	end

	assign hs_ram_bytes = ram_bytes_ff;
	assign code_store_kb = rom_kb_ff;
	assign expansion_bytes = exp_bytes_ff;
	assign size_code_bad = bad_ff;

	// Strap synchroniser, three stages
	logic strap_s1_ff;
	logic strap_s2_ff;
	logic strap_s3_ff;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			strap_s1_ff <= 1'b0;
			strap_s2_ff <= 1'b0;
			strap_s3_ff <= 1'b0;
		end else begin
			strap_s1_ff <= program_mode_select_pin;
			strap_s2_ff <= strap_s1_ff;
			strap_s3_ff <= strap_s2_ff;
		end
	end

	// Strap is sampled once after release, when stages agree and the
	// chain has flushed its reset zeros
	logic [1:0] settle_ff;
	logic [1:0] nxt_settle;
	logic captured_ff;
	logic prog_mode_ff;

	wire settled = (settle_ff == STRAP_SETTLE);
	wire strap_agree = (strap_s2_ff == strap_s3_ff);
	wire do_capture = settled & strap_agree & ~captured_ff;
	assign nxt_settle = settled ? settle_ff : settle_ff + 2'h1;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			settle_ff <= 2'h0;
			captured_ff <= 1'b0;
			prog_mode_ff <= 1'b0;
		end else begin
			settle_ff <= nxt_settle;
			if (do_capture) begin
				captured_ff <= 1'b1;
				prog_mode_ff <= strap_s3_ff;
			end
		end
	end

	assign prog_mode = prog_mode_ff;

	// Clock source check per channel; the async channel cannot run
	// from any source outside the three allowed ones
	logic clk_ok;

	always_comb begin
		case (prog_chan_sel)
			CHAN_CLOCKED: clk_ok = (clk_src_sel == CLK_HS_OSC);
			CHAN_ASYNC: clk_ok = (clk_src_sel == CLK_HS_OSC) |
				(clk_src_sel == CLK_CRYSTAL) |
				(clk_src_sel == CLK_EXT_MAIN);
			default: clk_ok = 1'b0;
		endcase
	end

	assign prog_clk_ok = clk_ok;

	// Only one channel is opened, and only in programming mode
	wire chan_go = prog_mode_ff & clk_ok;
	assign clocked_serial_channel_en =
		chan_go & (prog_chan_sel == CHAN_CLOCKED);
	assign async_serial_channel_en =
		chan_go & (prog_chan_sel == CHAN_ASYNC);

endmodule

// ---- pkg/mss_pkg.sv ----
// Constants, types and register map for the memory size configuration block.
// Assumes an 8-bit CPU data path with 16-bit byte addresses.
package mss_pkg;

	// Register byte addresses
	localparam logic [15:0] MEM_SIZE_ADDR = 16'hfff0;
	localparam logic [15:0] EXP_SIZE_ADDR = 16'hfff4;

	// Reset values
	localparam logic [7:0] MEM_SIZE_RST = 8'hcf;
	localparam logic [7:0] EXP_SIZE_RST = 8'h0c;

	// Writable bit masks; other bits hold zero
	localparam logic [7:0] MEM_SIZE_MASK = 8'hef;
	localparam logic [7:0] EXP_SIZE_MASK = 8'h1f;

	// Field positions
	localparam int RAM_FLD_LSB = 5;
	localparam int RAM_FLD_MSB = 7;
	localparam int ROM_FLD_LSB = 0;
	localparam int ROM_FLD_MSB = 3;
	localparam int EXP_FLD_LSB = 0;
	localparam int EXP_FLD_MSB = 4;

	// High-speed RAM field codes
	localparam logic [2:0] RAM_CODE_768 = 3'h0;
	localparam logic [2:0] RAM_CODE_1024 = 3'h6;

	// Code store field codes
	localparam logic [3:0] ROM_CODE_16K = 4'h4;
	localparam logic [3:0] ROM_CODE_24K = 4'h6;
	localparam logic [3:0] ROM_CODE_32K = 4'h8;
	localparam logic [3:0] ROM_CODE_48K = 4'hc;
	localparam logic [3:0] ROM_CODE_60K = 4'hf;

	// Expansion RAM field codes
	localparam logic [4:0] EXP_CODE_NONE = 5'h0c;
	localparam logic [4:0] EXP_CODE_1024 = 5'h0a;

	// Decoded capacities
	localparam logic [10:0] RAM_BYTES_768 = 11'h300;
	localparam logic [10:0] RAM_BYTES_1024 = 11'h400;
	localparam logic [10:0] EXP_BYTES_NONE = 11'h000;
	localparam logic [10:0] EXP_BYTES_1024 = 11'h400;
	localparam logic [5:0] ROM_KB_16 = 6'h10;
	localparam logic [5:0] ROM_KB_24 = 6'h18;
	localparam logic [5:0] ROM_KB_32 = 6'h20;
	localparam logic [5:0] ROM_KB_48 = 6'h30;
	localparam logic [5:0] ROM_KB_60 = 6'h3c;

	// Settling count of the strap synchroniser before capture
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	// Clock source identifiers
	typedef enum logic [1:0] {
		CLK_HS_OSC = 2'h0,
		CLK_CRYSTAL = 2'h1,
		CLK_EXT_MAIN = 2'h2,
		CLK_OTHER = 2'h3
	} mss_clk_src_t;

	// Programming channel identifiers
	typedef enum logic {
		CHAN_CLOCKED = 1'b0,
		CHAN_ASYNC = 1'b1
	} mss_chan_t;

endpackage

// ---- pkg/mss_reg_if.sv ----
// Carrier between the top and one byte register instance.
// Assumes the top drives write strobe and data on core_clk.
`timescale 1ns/10ps
interface mss_reg_if;
	logic wr_en;
	logic [7:0] wdata;
	logic [7:0] q;
	modport ctrl (output wr_en, output wdata, input q);
	modport regs (input wr_en, input wdata, output q);
endinterface

// ---- design/mss_byte_reg.sv ----
// One 8-bit configuration register with reset value and writable mask.
// Assumes the write strobe is already qualified for whole-byte access.
`timescale 1ns/10ps
module mss_byte_reg #(
	parameter logic [7:0] RST_VAL = 8'h00,
	parameter logic [7:0] WR_MASK = 8'hff
) (
	input wire logic core_clk,
	input wire logic rst_b,
	mss_reg_if.regs bus
);
	logic [7:0] val_ff;
	logic [7:0] nxt_val;

	// Masked bits stay zero, so reserved bits read back as zero
	assign nxt_val = bus.wr_en ? (bus.wdata & WR_MASK) : val_ff;
	assign bus.q = val_ff;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			val_ff <= RST_VAL;
		end else begin
			val_ff <= nxt_val;
		end
	end
endmodule

// ---- tb/mss_top_properties.sv ----
// Checker for the memory size registers, bound to mss_top.
// Assumes the bench holds cpu_rd_en high while it writes.
`timescale 1ns/10ps
module mss_top_properties
	import mss_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [15:0] cpu_addr,
	input wire logic cpu_wr_en,
	input wire logic cpu_rd_en,
	input wire logic cpu_byte_acc,
	input wire logic [7:0] cpu_wdata,
	input wire logic [7:0] cpu_rdata,
	input wire logic cpu_rd_hit,
	input wire mss_pkg::mss_chan_t prog_chan_sel,
	input wire mss_pkg::mss_clk_src_t clk_src_sel,
	input wire logic [10:0] hs_ram_bytes,
	input wire logic [10:0] expansion_bytes,
	input wire logic prog_mode,
	input wire logic clocked_serial_channel_en,
	input wire logic async_serial_channel_en
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	wire rm = cpu_rd_en && cpu_addr == MEM_SIZE_ADDR;
	wire rx = cpu_rd_en && cpu_addr == EXP_SIZE_ADDR;
	wire wb = cpu_wr_en && cpu_byte_acc;
	chk_mem_write: assert property (
		wb && rm ##1 rm |-> cpu_rdata == ($past(cpu_wdata) & MEM_SIZE_MASK))
		else $error("memory size readback");
	chk_exp_write: assert property (
		wb && rx ##1 rx |-> cpu_rdata == ($past(cpu_wdata) & EXP_SIZE_MASK))
		else $error("expansion readback");
	chk_read_hit: assert property (cpu_rd_hit == (rm || rx))
		else $error("read hit");
	chk_unmapped_zero: assert property (
		cpu_rd_en && !cpu_rd_hit |-> cpu_rdata == 8'h00)
		else $error("unmapped data");
	chk_ram_decode: assert property (
		rm ##1 rm && $stable(cpu_rdata) |-> hs_ram_bytes ==
		(cpu_rdata[7:5] == RAM_CODE_1024 ? RAM_BYTES_1024 : RAM_BYTES_768))
		else $error("ram decode");
	chk_exp_decode: assert property (
		rx ##1 rx && $stable(cpu_rdata) |-> expansion_bytes ==
		(cpu_rdata[4:0] == EXP_CODE_1024 ? EXP_BYTES_1024 : EXP_BYTES_NONE))
		else $error("expansion decode");
	chk_clocked_source: assert property (
		clocked_serial_channel_en == (prog_mode &&
		prog_chan_sel == CHAN_CLOCKED && clk_src_sel == CLK_HS_OSC))
		else $error("clocked enable");
	chk_async_source: assert property (
		async_serial_channel_en == (prog_mode &&
		prog_chan_sel == CHAN_ASYNC && clk_src_sel != CLK_OTHER))
		else $error("async enable");
	cover property (wb && rm);
	cover property (clocked_serial_channel_en);
	cover property (async_serial_channel_en);
endmodule
bind mss_top mss_top_properties mss_top_properties_i (.*);

// ---- tb/mss_top_test.sv ----
// Bench for mss_top: write table, then refused writes, reset, channels.
// Assumes the package, design and checker are compiled first.
`timescale 1ns/10ps
module mss_top_test;
	import mss_pkg::*;
	logic core_clk = 0, rst_b, cpu_wr_en = 0, cpu_rd_en = 1;
	logic cpu_byte_acc = 1, program_mode_select_pin, cpu_rd_hit;
	logic [15:0] cpu_addr = 16'hfff0;
	logic [7:0] cpu_wdata = 8'h00, cpu_rdata;
	logic prog_mode, prog_clk_ok;
	logic clocked_serial_channel_en, async_serial_channel_en;
	logic [10:0] hs_ram_bytes, expansion_bytes;
	logic [5:0] code_store_kb;
	logic [2:0] size_code_bad;
	mss_chan_t prog_chan_sel = CHAN_CLOCKED;
	mss_clk_src_t clk_src_sel = CLK_HS_OSC;
	int err_count = 0, n_checks = 0, cyc = 0;
	typedef struct {logic [15:0] a; logic [7:0] w, r; logic [10:0] b;
		logic [5:0] k; logic [2:0] e;} mss_row_t;
	// Prohibited codes first: they must decode to the smallest size
	mss_row_t rows [9] = '{'{16'hfff0, 8'h55, 8'h45, 11'h300, 6'h10, 3'h3},
		'{16'hfff0, 8'h04, 8'h04, 11'h300, 6'h10, 3'h0},
		'{16'hfff0, 8'hc6, 8'hc6, 11'h400, 6'h18, 3'h0},
		'{16'hfff0, 8'hc8, 8'hc8, 11'h400, 6'h20, 3'h0},
		'{16'hfff0, 8'hcc, 8'hcc, 11'h400, 6'h30, 3'h0},
		'{16'hfff0, 8'hcf, 8'hcf, 11'h400, 6'h3c, 3'h0},
		'{16'hfff4, 8'hff, 8'h1f, 11'h000, 6'h3c, 3'h4},
		'{16'hfff4, 8'h0a, 8'h0a, 11'h400, 6'h3c, 3'h0},
		'{16'hfff4, 8'h0c, 8'h0c, 11'h000, 6'h3c, 3'h0}};
	mss_top mss_top_i (.*);
	initial forever #5 core_clk = ~core_clk;
	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			wrap_up;
		end
	end
	task chk(input string n, input logic [10:0] x, g);
		n_checks++;
		if (g !== x) begin
			err_count++;
			$display("MISMATCH %s exp %h got %h", n, x, g);
		end
	endtask
	task st;
		@(posedge core_clk);
		#1;
	endtask
	// Leaves the strobe high so back-to-back calls need no gap
	task wr(input logic [15:0] a, input logic [7:0] d, input logic b);
		cpu_addr = a;
		cpu_wdata = d;
		cpu_byte_acc = b;
		cpu_wr_en = 1;
		st;
	endtask
	task rst(input logic p);
		program_mode_select_pin = p;
		rst_b = 0;
		repeat (8) st;
		rst_b = 1;
		repeat (6) st;
	endtask
	initial begin
		rst(0);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w, 1);
			cpu_wr_en = 0;
			chk("rdata", rows[i].r, cpu_rdata);
			st;
			chk("size", rows[i].b,
				rows[i].a[2] ? expansion_bytes : hs_ram_bytes);
			chk("kb", rows[i].k, code_store_kb);
			chk("bad", rows[i].e, size_code_bad);
		end
		$display("table done");
		wr(16'hfff0, 8'h04, 0);
		wr(16'hfff4, 8'h0a, 0);
		wr(16'hfff1, 8'h04, 1);
		cpu_wr_en = 0;
		chk("unmapped", 0, cpu_rdata);
		st;
		chk("ram", 11'h400, hs_ram_bytes);
		chk("exp", 0, expansion_bytes);
		wr(16'hfff0, 8'hc8, 1);
		wr(16'hfff4, 8'h0a, 1);
		cpu_wr_en = 0;
		st;
		chk("kb", 6'h20, code_store_kb);
		chk("exp", 11'h400, expansion_bytes);
		rst(1);
		chk("exp_reg", 8'h0c, cpu_rdata);
		chk("exp", 0, expansion_bytes);
		chk("kb", 6'h3c, code_store_kb);
		chk("mode", 1, prog_mode);
		// Read strobe is otherwise always high, so drop it once here
		cpu_addr = 16'hfff0;
		st;
		chk("mem_reg", 8'hcf, cpu_rdata);
		chk("hit_on", 1, cpu_rd_hit);
		cpu_rd_en = 0;
		st;
		chk("hit_off", 0, cpu_rd_hit);
		cpu_rd_en = 1;
		program_mode_select_pin = 0;
		for (int c = 0; c < 2; c++)
			for (int s = 0; s < 4; s++) begin
				prog_chan_sel = mss_chan_t'(c);
				clk_src_sel = mss_clk_src_t'(s);
				st;
				chk("ok", c ? s != 3 : s == 0, prog_clk_ok);
				chk("clk_ch", !c && !s, clocked_serial_channel_en);
				chk("as_ch", c && s != 3, async_serial_channel_en);
			end
		rst(0);
		chk("mode", 0, prog_mode);
		$display("reset and channel tests done");
		wrap_up;
	end
endmodule
